/* File: gcim_defines.svh */
`ifndef GCIM_DEFINES_SVH
`define GCIM_DEFINES_SVH

// ****************************************
// Register indices (byte address = index * 4)
// ****************************************
`define GCIM_IDX_TRIG0 16'hD010
`define GCIM_IDX_TRIG3 16'hD013
`define GCIM_IDX_CONSOLE_SW 16'hD01F
`define GCIM_IDX_POT0 16'hD200
`define GCIM_IDX_POT7 16'hD207
`define GCIM_IDX_KEY_CODE 16'hD209
`define GCIM_IDX_INT_STATUS 16'hD20E
`define GCIM_IDX_SER_KEY 16'hD20F

// ****************************************
// Field positions
// ****************************************
`define GCIM_CSW_SEL_LO 0
`define GCIM_CSW_POT_PWR 2
`define GCIM_SKC_DEBOUNCE 0
`define GCIM_SKS_KEY_DOWN 2
`define GCIM_SKS_SHIFT 3
`define GCIM_INT_KEY 6
`define GCIM_INT_BREAK 7

// ****************************************
// Reset values and limits
// ****************************************
`define GCIM_CSW_RESET 8'h00
`define GCIM_SKC_RESET 8'h00
`define GCIM_SKS_IDLE 8'hFF
`define GCIM_POT_MAX 8'hE4
`define GCIM_SCAN_LAST 6'h3F

// ****************************************
// Timing
// ****************************************
`define GCIM_CLK_MHZ 100
`define GCIM_LINE_NS 64000
`define GCIM_LINE_CYCLES ((`GCIM_LINE_NS * `GCIM_CLK_MHZ) / 1000)

`endif

/* File: gcim_pkg.sv */
`default_nettype none
package gcim_pkg;
  typedef logic [31:0] gcim_word_t;
  typedef logic [17:0] gcim_addr_t;
  typedef logic [14:0] gcim_keys_t;
  typedef logic [2:0] gcim_pot_idx_t;
  typedef enum logic [0:0] {KB_SCAN, KB_HOLD} gcim_kb_state_e;
endpackage
`default_nettype wire

/* File: gcim_pot_if.sv */
`timescale 1ns/100ps
`default_nettype none
interface gcim_pot_if;
  logic we;
  logic [2:0] waddr;
  logic [7:0] wdata;
  logic [2:0] raddr;
  logic [7:0] rdata;
  modport client (output we, output waddr, output wdata, output raddr, input rdata);
  modport store (input we, input waddr, input wdata, input raddr, output rdata);
endinterface
`default_nettype wire

/* File: gcim_pot_mem.sv */
`timescale 1ns/100ps
`default_nettype none
`include "gcim_defines.svh"
module gcim_pot_mem (
  input wire logic clk,
  input wire logic rst_n,
  gcim_pot_if.store port
);
  import gcim_pkg::*;

  logic [7:0] mem_q [8];
  logic [7:0] rdata_q;

  // Entries start at full count, as with the sticks unpowered
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < 8; i++) begin
        mem_q[i] <= `GCIM_POT_MAX;
      end
    end else if (port.we) begin
      mem_q[port.waddr] <= port.wdata;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rdata_q <= `GCIM_POT_MAX;
    end else begin
      rdata_q <= mem_q[port.raddr];
    end
  end

  assign port.rdata = rdata_q;
endmodule
`default_nettype wire

/* File: gcim_input_mux.sv */
`timescale 1ns/100ps
`default_nettype none
`include "gcim_defines.svh"
// Overview of operation
// - Select field picks one keypad and top button
// - Bottom buttons and sticks bypass the select
// - Even counters horizontal, odd counters vertical
// - Stick power off: counters read 228
// - Console switch lines are outputs only
// - Keypad keys map to fixed four-bit codes
// - Unused scan code bits make every key match four codes
// - Debounce on: presses are never reported
// - Debounce off: held key reported every 32 lines
// - Debounce re-enabled quickly: wait for release
// - Bottom button drives its own trigger input
// - Top button acts as shift, break interrupt
module gcim_input_mux #(
  parameter int LINE_CYCLES = `GCIM_LINE_CYCLES
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire gcim_pkg::gcim_addr_t paddr,
  input wire gcim_pkg::gcim_word_t pwdata,
  output gcim_pkg::gcim_word_t prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [59:0] keypad_n,
  input wire logic [3:0] top_btn_n,
  input wire logic [3:0] bottom_btn_n,
  input wire logic [7:0] pot_cmp,
  output logic [3:0] console_sw
);
  import gcim_pkg::*;

  // ****************************************
  // Decoders
  // ****************************************
  function automatic logic in_range(input logic [15:0] idx, input logic [15:0] lo, input logic [15:0] hi);
    in_range = (idx >= lo) && (idx <= hi);
  endfunction

  // Key slot k carries code 15-k; code 0000 is no key
  function automatic gcim_keys_t key_mask(input logic [3:0] code);
    gcim_keys_t m;
    m = '0;
    for (int k = 0; k < 15; k++) begin
      if (code == 4'(15 - k)) begin
        m[k] = 1'b1;
      end
    end
    key_mask = m;
  endfunction

  // ****************************************
  // Pin synchronisers
  // ****************************************
  localparam logic [75:0] SYNC_IDLE = {8'h00, {68{1'b1}}};
  logic [75:0] sync_raw, sync1_q, sync2_q, sync3_q, pin_q;

  assign sync_raw = {pot_cmp, bottom_btn_n, top_btn_n, keypad_n};

  // A change is taken only once the last two stages agree
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync1_q <= SYNC_IDLE;
      sync2_q <= SYNC_IDLE;
      sync3_q <= SYNC_IDLE;
      pin_q <= SYNC_IDLE;
    end else begin
      sync1_q <= sync_raw;
      sync2_q <= sync1_q;
      sync3_q <= sync2_q;
      pin_q <= (sync2_q & sync3_q) | (pin_q & (sync2_q ^ sync3_q));
    end
  end

  logic [59:0] keys_down;
  logic [3:0] top_down, bottom_level_n;
  logic [7:0] pot_reached;
  assign keys_down = ~pin_q[59:0];
  assign top_down = ~pin_q[63:60];
  assign bottom_level_n = pin_q[67:64];
  assign pot_reached = pin_q[75:68];

  // ****************************************
  // Registers held by software
  // ****************************************
  logic [7:0] csw_q, skc_q;
  logic pot_pwr, debounce;
  logic [3:0] sel_en;

  assign pot_pwr = csw_q[`GCIM_CSW_POT_PWR];
  assign debounce = skc_q[`GCIM_SKC_DEBOUNCE];
  assign sel_en = 4'b0001 << csw_q[`GCIM_CSW_SEL_LO +: 2];
  assign console_sw = csw_q[3:0];

  // ****************************************
  // Controller multiplexer
  // ****************************************
  gcim_keys_t key_acc [5];
  logic [4:0] top_acc;
  assign key_acc[0] = '0;
  assign top_acc[0] = 1'b0;

  // Unselected slots are forced to zero before the merge
  for (genvar g = 0; g < 4; g++) begin : gen_slot
    assign key_acc[g + 1] = key_acc[g] | (sel_en[g] ? keys_down[g * 15 +: 15] : '0);
    assign top_acc[g + 1] = top_acc[g] | (sel_en[g] & top_down[g]);
  end

  gcim_keys_t sel_keys;
  logic top_sel;
  assign sel_keys = key_acc[4];
  assign top_sel = top_acc[4];

  // ****************************************
  // Scan line timing
  // ****************************************
  logic [15:0] line_cnt_q;
  logic line_tick;
  logic [5:0] scan_q;

  assign line_tick = (line_cnt_q == 16'(LINE_CYCLES - 1));

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      line_cnt_q <= '0;
      scan_q <= '0;
    end else if (line_tick) begin
      line_cnt_q <= '0;
      scan_q <= scan_q + 6'h01;
    end else begin
      line_cnt_q <= line_cnt_q + 16'h0001;
    end
  end

  // ****************************************
  // Keyboard scan
  // ****************************************
  gcim_kb_state_e kb_state_q;
  logic prev_hit_q, scan_any_q, recent_q, key_down_q;
  logic key_hit, report, enter_hold, scan_end, scan_clean;
  logic [7:0] key_code_q;

  // Bits 0 and 5 of the scan code take no part, so a key matches four codes
  assign key_hit = |(sel_keys & key_mask(scan_q[4:1]));
  assign scan_end = line_tick && (scan_q == `GCIM_SCAN_LAST);
  assign scan_clean = !scan_any_q && !key_hit;
  // A hit right after a miss is reported; the twin match lands 32 lines on
  assign report = line_tick && key_hit && !prev_hit_q && !debounce && (kb_state_q == KB_SCAN);
  assign enter_hold = (kb_state_q == KB_SCAN) && debounce && recent_q;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      kb_state_q <= KB_SCAN;
    end else begin
      case (kb_state_q)
        KB_SCAN: begin
          if (enter_hold) begin
            kb_state_q <= KB_HOLD;
          end
        end
        KB_HOLD: begin
          // Leave only after a whole scan without the key
          if (scan_end && scan_clean) begin
            kb_state_q <= KB_SCAN;
          end
        end
        default: begin
          kb_state_q <= KB_SCAN;
        end
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prev_hit_q <= 1'b0;
      scan_any_q <= 1'b0;
    end else if (line_tick) begin
      prev_hit_q <= key_hit;
      scan_any_q <= scan_end ? 1'b0 : (scan_any_q | key_hit);
    end
  end

  // Window for re-enabling debounce closes at the next line
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      recent_q <= 1'b0;
    end else if (report) begin
      recent_q <= 1'b1;
    end else if (line_tick) begin
      recent_q <= 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      key_down_q <= 1'b0;
    end else if (report) begin
      key_down_q <= 1'b1;
    end else if (scan_end && scan_clean) begin
      key_down_q <= 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      key_code_q <= '0;
    end else if (report) begin
      key_code_q <= {top_sel, top_sel, scan_q};
    end
  end

  // ****************************************
  // Interrupt status flags
  // ****************************************
  logic top_prev_q, int_key_q, int_brk_q;
  logic break_rise, clr_key, clr_brk;

  assign break_rise = top_sel && !top_prev_q;

  // Set beats a clear arriving in the same cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      top_prev_q <= 1'b0;
      int_key_q <= 1'b0;
      int_brk_q <= 1'b0;
    end else begin
      top_prev_q <= top_sel;
      int_key_q <= report | (int_key_q & !clr_key);
      int_brk_q <= break_rise | (int_brk_q & !clr_brk);
    end
  end

  // ****************************************
  // Potentiometer counters
  // ****************************************
  logic [7:0] pot_line_q;
  logic dump_q, frame_end, dump_done;
  gcim_pot_idx_t dump_idx_q;
  logic [63:0] pot_cnt;

  assign frame_end = line_tick && (pot_line_q == `GCIM_POT_MAX);
  assign dump_done = dump_q && (dump_idx_q == 3'h7);

  // Even slots carry horizontal axes, odd slots vertical; wiring keeps the pairing
  for (genvar p = 0; p < 8; p++) begin : gen_pot
    logic [7:0] cnt_q;
    logic stop;
    // Without stick power the comparator is ignored and the count runs to full
    assign stop = pot_pwr && pot_reached[p];
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        cnt_q <= '0;
      end else if (dump_done) begin
        cnt_q <= '0;
      end else if (line_tick && !stop && (cnt_q < `GCIM_POT_MAX)) begin
        cnt_q <= cnt_q + 8'h01;
      end
    end
    assign pot_cnt[p * 8 +: 8] = cnt_q;
  end

  // Counters are copied into the store one per cycle after each frame
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pot_line_q <= '0;
      dump_q <= 1'b0;
      dump_idx_q <= '0;
    end else begin
      if (frame_end) begin
        pot_line_q <= '0;
      end else if (line_tick) begin
        pot_line_q <= pot_line_q + 8'h01;
      end
      if (frame_end) begin
        dump_q <= 1'b1;
      end else if (dump_done) begin
        dump_q <= 1'b0;
      end
      dump_idx_q <= dump_q ? dump_idx_q + 3'h1 : 3'h0;
    end
  end

  gcim_pot_if pot_bus ();
  assign pot_bus.we = dump_q;
  assign pot_bus.waddr = dump_idx_q;
  assign pot_bus.wdata = pot_cnt[dump_idx_q * 8 +: 8];
  assign pot_bus.raddr = paddr[4:2];

  gcim_pot_mem u_pot_mem (
    .clk(pclk),
    .rst_n(presetn),
    .port(pot_bus.store)
  );

  // ****************************************
  // APB slave
  // ****************************************
  logic [15:0] idx;
  logic aligned, mapped, phase_q, wr_fire;
  logic hit_trig, hit_csw, hit_pot, hit_kcode, hit_int, hit_ser;
  logic [7:0] serial_key_status, rd_byte;
  gcim_word_t prdata_q;

  assign idx = paddr[17:2];
  assign aligned = (paddr[1:0] == 2'b00);
  assign hit_trig = aligned && in_range(idx, `GCIM_IDX_TRIG0, `GCIM_IDX_TRIG3);
  assign hit_csw = aligned && in_range(idx, `GCIM_IDX_CONSOLE_SW, `GCIM_IDX_CONSOLE_SW);
  assign hit_pot = aligned && in_range(idx, `GCIM_IDX_POT0, `GCIM_IDX_POT7);
  assign hit_kcode = aligned && in_range(idx, `GCIM_IDX_KEY_CODE, `GCIM_IDX_KEY_CODE);
  assign hit_int = aligned && in_range(idx, `GCIM_IDX_INT_STATUS, `GCIM_IDX_INT_STATUS);
  assign hit_ser = aligned && in_range(idx, `GCIM_IDX_SER_KEY, `GCIM_IDX_SER_KEY);
  assign mapped = hit_trig | hit_csw | hit_pot | hit_kcode | hit_int | hit_ser;

  // One wait state gives the pot store time to present its registered word
  assign pready = psel && penable && phase_q;
  assign pslverr = pready && !mapped;
  assign wr_fire = pready && pwrite && mapped;
  assign clr_key = wr_fire && hit_int && pwdata[`GCIM_INT_KEY];
  assign clr_brk = wr_fire && hit_int && pwdata[`GCIM_INT_BREAK];

  // Status bits read low while active
  assign serial_key_status = `GCIM_SKS_IDLE & ~(8'(key_down_q) << `GCIM_SKS_KEY_DOWN) & ~(8'(top_sel) << `GCIM_SKS_SHIFT);

  assign rd_byte = hit_trig ? {7'h00, bottom_level_n[idx[1:0]]} :
                   hit_csw ? csw_q :
                   hit_pot ? (pot_pwr ? pot_bus.rdata : `GCIM_POT_MAX) :
                   hit_kcode ? key_code_q :
                   hit_int ? {int_brk_q, int_key_q, 6'h00} :
                   hit_ser ? serial_key_status : 8'h00;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      phase_q <= 1'b0;
      prdata_q <= '0;
    end else begin
      phase_q <= psel && penable && !phase_q;
      if (psel && penable && !phase_q) begin
        prdata_q <= {24'h000000, rd_byte};
      end
    end
  end

  assign prdata = prdata_q;

  // Writes to read-only words are dropped
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      csw_q <= `GCIM_CSW_RESET;
      skc_q <= `GCIM_SKC_RESET;
    end else begin
      if (wr_fire && hit_csw) begin
        csw_q <= pwdata[7:0];
      end
      if (wr_fire && hit_ser) begin
        skc_q <= pwdata[7:0];
      end
    end
  end
endmodule
`default_nettype wire

/* File: gcim_input_mux_assertions.sv */
`timescale 1ns/100ps
`default_nettype none
`include "gcim_defines.svh"
module gcim_input_mux_assertions (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire gcim_pkg::gcim_addr_t paddr,
  input wire gcim_pkg::gcim_word_t pwdata,
  input wire gcim_pkg::gcim_word_t prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic [3:0] bottom_btn_n,
  input wire logic [3:0] console_sw
);
  import gcim_pkg::*;
  default clocking @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  localparam gcim_addr_t A_CSW = {`GCIM_IDX_CONSOLE_SW, 2'b00};
  localparam gcim_addr_t A_TRIG0 = {`GCIM_IDX_TRIG0, 2'b00};
  wire logic csw_wr = pready && pwrite && !pslverr && paddr == A_CSW;
  wire logic rd_done = pready && !pwrite;
  sequence s_setup;
    psel && !penable;
  endsequence
  sequence s_access;
    psel && penable;
  endsequence
  property p_one_wait;
    s_setup ##1 s_access |-> !pready ##1 pready;
  endproperty
  property p_err_ready;
    pslverr |-> pready;
  endproperty
  property p_rdy_pulse;
    pready |=> !pready;
  endproperty
  property p_misalign;
    pready && paddr[1:0] != 2'b00 |-> pslverr;
  endproperty
  property p_err_zero;
    rd_done && pslverr |-> prdata == 32'h0;
  endproperty
  property p_upper_zero;
    rd_done |-> prdata[31:8] == 24'h0;
  endproperty
  property p_csw_follow;
    csw_wr |=> console_sw == $past(pwdata[3:0]);
  endproperty
  property p_csw_hold;
    !csw_wr |=> $stable(console_sw);
  endproperty
  // Pin must settle through the synchronizer before the read is judged
  property p_trig;
    $stable(bottom_btn_n)[*8] ##0 (rd_done && paddr == A_TRIG0) |-> prdata[0] == bottom_btn_n[0];
  endproperty
  a_one_wait: assert property (p_one_wait)
    else $error("pready not on second access cycle");
  a_err_ready: assert property (p_err_ready)
    else $error("pslverr without pready");
  a_rdy_pulse: assert property (p_rdy_pulse)
    else $error("pready longer than one cycle");
  a_misalign: assert property (p_misalign)
    else $error("unaligned access without error");
  a_err_zero: assert property (p_err_zero)
    else $error("refused read returned data");
  a_upper_zero: assert property (p_upper_zero)
    else $error("read data upper bits not zero");
  a_csw_follow: assert property (p_csw_follow)
    else $error("console lines differ from written value");
  a_csw_hold: assert property (p_csw_hold)
    else $error("console lines changed without write");
  a_trig: assert property (p_trig)
    else $error("trigger read differs from bottom button");
endmodule
bind gcim_input_mux gcim_input_mux_assertions gcim_input_mux_assertions_inst (.pclk, .presetn, .psel, .penable,
  .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .bottom_btn_n, .console_sw);
`default_nettype wire

/* File: gcim_pad_model.sv */
`timescale 1ns/100ps
`default_nettype none
module gcim_pad_model (
  input wire logic [15:0] keys,
  input wire logic [3:0] top,
  input wire logic [3:0] bot,
  input wire logic [7:0] cmp,
  output logic [59:0] keypad_n,
  output logic [3:0] top_btn_n,
  output logic [3:0] bottom_btn_n,
  output logic [7:0] pot_cmp
);
  // One key per controller; nibble 15 means none held
  always_comb begin
    keypad_n = '1;
    for (int c = 0; c < 4; c++) begin
      if (keys[c*4+:4] != 4'hF) begin
        keypad_n[c*15+keys[c*4+:4]] = 1'b0;
      end
    end
  end
  assign top_btn_n = ~top;
  assign bottom_btn_n = ~bot;
  assign pot_cmp = cmp;
endmodule
`default_nettype wire

/* File: gcim_input_mux_tb.sv */
`timescale 1ns/100ps
`default_nettype none
`include "gcim_defines.svh"
module gcim_input_mux_tb;
  import gcim_pkg::*;
  localparam int LC = 16;
  localparam logic [15:0] CSW = `GCIM_IDX_CONSOLE_SW;
  localparam logic [15:0] INT = `GCIM_IDX_INT_STATUS;
  localparam logic [15:0] KEY = `GCIM_IDX_KEY_CODE;
  localparam logic [15:0] SK = `GCIM_IDX_SER_KEY;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, er;
  gcim_addr_t paddr;
  gcim_word_t pwdata, prdata, rd;
  logic [59:0] keypad_n;
  logic [3:0] top_btn_n, bottom_btn_n, console_sw, top, bot;
  logic [7:0] pot_cmp, cmp;
  logic [15:0] keys, kv;
  int num_errors, comparisons, s;
  gcim_input_mux #(.LINE_CYCLES(LC)) gcim_input_mux_inst (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .keypad_n, .top_btn_n, .bottom_btn_n, .pot_cmp, .console_sw);
  gcim_pad_model gcim_pad_model_inst (.keys, .top, .bot, .cmp, .keypad_n, .top_btn_n, .bottom_btn_n, .pot_cmp);
  // ****************
  // Helpers
  // ****************
  function automatic logic [31:0] f_code(input int k);
    return 32'(15 - k) << 1;
  endfunction
  function automatic logic [31:0] f_pot(input int p, input logic c);
    return (p != 0 && c) ? 32'h0 : 32'(`GCIM_POT_MAX);
  endfunction
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    comparisons++;
    if (g !== e) begin
      num_errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  // Idle cycle first so release and next setup never share a time step
  task automatic apb(input logic w, input logic [15:0] i, input logic [7:0] d, input logic [1:0] lo = 2'b00);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= {i, lo};
    pwdata <= {24'h0, d};
    @(posedge pclk);
    penable <= 1'b1;
    // Only the watchdog ends a wait for ready
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rdc(input logic [15:0] i, input logic [31:0] m, input logic [31:0] e);
    apb(1'b0, i, 8'h00);
    chk(rd & m, e);
  endtask
  task automatic lines(input int k);
    repeat (k * LC) @(posedge pclk);
  endtask
  task automatic report_and_stop;
    if (num_errors == 0 && comparisons > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end
  initial begin
    #600000;
    num_errors++;
    report_and_stop();
  end
  // ****************
  // Scenarios
  // ****************
  initial begin
    presetn = 0;
    psel = 0;
    penable = 0;
    pwrite = 0;
    paddr = '0;
    pwdata = '0;
    keys = 16'hFFFF;
    top = 0;
    bot = 0;
    cmp = 0;
    num_errors = 0;
    comparisons = 0;
    void'($urandom(32'h5c3e48d8));
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    rdc(CSW, 32'hFF, 32'h0);
    apb(1'b0, 16'h0100, 8'h00);
    chk(32'(er), 32'h1);
    chk(rd, 32'h0);
    apb(1'b0, CSW, 8'h00, 2'b10);
    chk(32'(er), 32'h1);
    chk(rd, 32'h0);
    for (int p = 0; p < 4; p++) begin
      apb(1'b1, CSW, 8'(p));
      bot <= 4'($urandom);
      rdc(CSW, 32'h0F, 32'(p));
      chk(32'(console_sw), 32'(p));
      repeat (8) @(posedge pclk);
      for (int c = 0; c < 4; c++) rdc(16'(`GCIM_IDX_TRIG0 + c), 32'h1, 32'(!bot[c]));
    end
    for (int p = 0; p < 2; p++) begin
      cmp <= 8'($urandom);
      apb(1'b1, CSW, 8'(p * 4));
      lines(462);
      for (int i = 0; i < 8; i++) rdc(16'(`GCIM_IDX_POT0 + i), 32'hFF, f_pot(p, cmp[i]));
    end
    // Another controller holds a different key and tops flicker off the selected slot
    for (int k = 0; k < 15; k++) begin
      s = $urandom_range(3);
      kv = 16'hFFFF;
      kv[s*4+:4] = 4'(k);
      kv[((s+1)%4)*4+:4] = 4'((k + 1) % 15);
      keys <= kv;
      top <= 4'($urandom) & ~(4'h1 << s);
      apb(1'b1, CSW, 8'(s));
      lines(2);
      apb(1'b1, INT, 8'hC0);
      lines(34);
      rdc(INT, 32'hC0, 32'h40);
      rdc(KEY, 32'hDE, f_code(k));
      rdc(SK, 32'h04, 32'h0);
    end
    top <= 4'h0;
    lines(1);
    apb(1'b1, INT, 8'hC0);
    top <= 4'h1 << s;
    lines(34);
    rdc(INT, 32'h80, 32'h80);
    rdc(KEY, 32'hC0, 32'hC0);
    rdc(SK, 32'h08, 32'h0);
    top <= 4'h0;
    apb(1'b1, SK, 8'h01);
    lines(2);
    apb(1'b1, INT, 8'hC0);
    lines(70);
    rdc(INT, 32'h40, 32'h0);
    // Release to leave any hold, then raise debounce right after a report
    keys <= 16'hFFFF;
    lines(140);
    apb(1'b1, SK, 8'h00);
    keys <= kv;
    apb(1'b1, INT, 8'hC0);
    do apb(1'b0, INT, 8'h00); while (rd[6] !== 1'b1);
    apb(1'b1, SK, 8'h01);
    apb(1'b1, SK, 8'h00);
    apb(1'b1, INT, 8'hC0);
    lines(70);
    rdc(INT, 32'h40, 32'h0);
    keys <= 16'hFFFF;
    lines(140);
    keys <= kv;
    lines(34);
    rdc(INT, 32'h40, 32'h40);
    report_and_stop();
  end
endmodule
`default_nettype wire
